/* File: rtl/smce_defines.vh */
// Constants for the SPI master command engine: opcodes, IO modes, limits.
// Assumes a 40 MHz system clock; included by bare name from rtl/.
`ifndef SMCE_DEFINES_VH
`define SMCE_DEFINES_VH
// Command opcodes
`define SMCE_OP_DRIVE 3'h0
`define SMCE_OP_SELECT 3'h1
`define SMCE_OP_CYC_GAP 3'h2
`define SMCE_OP_TIME_GAP 3'h3
`define SMCE_OP_STREAM_OUT 3'h4
`define SMCE_OP_REPEAT_OUT 3'h5
`define SMCE_OP_STREAM_IN 3'h6
// IO modes
`define SMCE_IO_SINGLE 2'h0
`define SMCE_IO_TWO 2'h1
`define SMCE_IO_FOUR 2'h2
// Clock period in ns and time-gap ceiling (2 s)
`define SMCE_CLK_NS 32'd25
`define SMCE_NS_MAX 32'd2000000000
// Word length bounds
`define SMCE_WS_MIN 6'd2
`define SMCE_WS_MAX 6'd32
// One command: 1 MB in bits; one queue: 64 MB - 1 in bytes
`define SMCE_CMD_BITS_MAX 38'h0000800000
`define SMCE_Q_BYTES_MAX 36'h003ffffff
// Power-on clock: 1000 kHz, half period 20 system clocks
`define SMCE_RATE_DEF 17'd1000
`define SMCE_HALF_DEF 10'd20
`define SMCE_RATE_MIN 17'd31
// FSM states
`define SMCE_ST_IDLE 3'h0
`define SMCE_ST_DELAY 3'h1
`define SMCE_ST_LOAD 3'h2
`define SMCE_ST_SHIFT 3'h3
`define SMCE_ST_GAP 3'h4
`endif

/* File: rtl/smce_engine.v */
// SPI master command engine: runs host commands onto an SPI bus.
// Assumes commands arrive in order on the clk domain; io_in comes from pins.
// Summary of operation
// - Master clock mode must match the slave's mode.
// - No master command is taken while the slave function is enabled.
// - One command carries at most 1 MB; one queue at most 64 MB-1.
// - Four clock modes fix idle polarity and sampling edge.
// - Bit order picks high-first or low-first for send and receive.
// - Each select polarity bit: 1 active high, 0 active low.
// - Word gap is 0 or above 1 clock; none after the last word.
// - Enable mask gives each shared pin to select (1) or GPIO (0).
// - Drive command enables outputs on 1, releases them on 0.
// - Select command: 1 asserts, 0 deasserts, bit 0 is line 0.
// - Clock rate after reset is 1000 kHz.
// - Rate maps to a discrete rate not above request, at least 31 kHz.
// - Rate request of 0 changes nothing, only reports current rate.
// - Cycle gap idles the bus N clock periods, reports N.
// - Time gap rounds up to whole periods, reports applied ns.
// - Time gap of 0 or over 2 s queues no delay.
// - Word length is 2 to 32 bits.
// - Words are continuous bit concatenation; packing done by the host.
// - IO modes: single full duplex, two-line, four-line.
// - Repeat command sends one word value N times.
// - Commands run on the bus in the order taken.
// - Received words and their count return with the response.
// - Two/four-line read clocks with all data lines as inputs.
`include "smce_defines.vh"
`default_nettype none
module smce_engine (
  input wire clk,
  input wire nrst,
  input wire slave_en,
  input wire [1:0] clock_mode,
  input wire lsb_first,
  input wire [7:0] ss_polarity,
  input wire [7:0] ss_enable,
  input wire [7:0] gpio_out,
  input wire [7:0] gpio_oe_n,
  input wire [15:0] word_gap,
  input wire rate_req_valid,
  input wire [16:0] rate_req_khz,
  output wire [16:0] rate_khz,
  input wire queue_begin,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [1:0] cmd_io,
  input wire [5:0] cmd_wsize,
  input wire [31:0] cmd_count,
  input wire [31:0] cmd_arg,
  output wire cmd_reject,
  input wire tx_valid,
  output wire tx_ready,
  input wire [31:0] tx_word,
  output wire rx_valid,
  output wire [31:0] rx_word,
  output wire resp_valid,
  output wire [31:0] resp_value,
  output wire [31:0] resp_words,
  output wire sclk,
  output wire sclk_oe_n,
  output wire [7:0] ss_pin_out,
  output wire [7:0] ss_pin_oe_n,
  input wire [3:0] io_in,
  output wire [3:0] io_out,
  output wire [3:0] io_oe_n
);
  // Discrete rates: {rate kHz, half period in clocks}, not above request except requests below 31, which get 31
  function [26:0] rate_pick;
    input [16:0] req;
    begin
      if (req >= 17'd20000) rate_pick = {17'd20000, 10'd1};
      else if (req >= 17'd10000) rate_pick = {17'd10000, 10'd2};
      else if (req >= 17'd5000) rate_pick = {17'd5000, 10'd4};
      else if (req >= 17'd4000) rate_pick = {17'd4000, 10'd5};
      else if (req >= 17'd2000) rate_pick = {17'd2000, 10'd10};
      else if (req >= `SMCE_RATE_DEF) rate_pick = {`SMCE_RATE_DEF, `SMCE_HALF_DEF};
      else if (req >= 17'd500) rate_pick = {17'd500, 10'd40};
      else if (req >= 17'd250) rate_pick = {17'd250, 10'd80};
      else if (req >= 17'd125) rate_pick = {17'd125, 10'd160};
      else if (req >= 17'd50) rate_pick = {17'd50, 10'd400};
      else rate_pick = {`SMCE_RATE_MIN, 10'd645};
    end
  endfunction
  // Lines per clock cycle for an IO mode
  function [2:0] lanes;
    input [1:0] io;
    begin
      case (io)
        `SMCE_IO_TWO: lanes = 3'd2;
        `SMCE_IO_FOUR: lanes = 3'd4;
        default: lanes = 3'd1;
      endcase
    end
  endfunction
  // Chunk driven this cycle; highest bit goes on highest line
  function [3:0] tx_chunk;
    input [31:0] sr;
    input [2:0] bw;
    input lsb;
    reg [31:0] hi;
    begin
      hi = sr >> (6'd32 - {3'h0, bw});
      tx_chunk = (lsb ? sr[3:0] : hi[3:0]) & ((4'h1 << bw) - 4'h1);
    end
  endfunction
  // Low-bit mask for a word length
  function [31:0] wmask;
    input [5:0] ws;
    begin
      wmask = (ws >= `SMCE_WS_MAX) ? 32'hffffffff : ((32'h1 << ws) - 32'h1);
    end
  endfunction
  // Reset release through two flops
  reg rst_m_q, rst_n_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end
  // Pin input synchroniser
  reg [3:0] io_m_q, io_s_q;
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end
  reg [2:0] st_q, op_q;
  reg [1:0] io_q;
  reg [5:0] ws_q, cyc_q, pad_q, lsh_q;
  reg [9:0] hc_q, half_q;
  reg ph_q, nsm_q, out_en_q, rej_q, rxv_q, rspv_q, sclk_q;
  reg [31:0] wcnt_q, wrx_q, arg_q, sr_q, rx_q, rem_q, acc_q;
  reg [31:0] rxw_q, rspval_q, rspw_q;
  reg [16:0] rate_q;
  reg [7:0] ss_act_q, ss_out_q, ss_oe_n_q;
  reg [3:0] io_out_q, io_oe_n_q;
  reg [25:0] qbytes_q;
  wire cpol = clock_mode[1];
  wire cpha = clock_mode[0];
  wire [2:0] bw = lanes(io_q);
  wire half_end = (hc_q == half_q - 10'd1);
  wire [37:0] bits = {32'h0, cmd_wsize} * {6'h0, cmd_count};
  wire [34:0] nbytes = bits[37:3] + {34'h0, |bits[2:0]};
  wire [35:0] qsum = {10'h0, qbytes_q} + {1'b0, nbytes};
  wire xfer_cmd = (cmd_op >= `SMCE_OP_STREAM_OUT) && (cmd_op <= `SMCE_OP_STREAM_IN);
  wire bad_len = (cmd_wsize < `SMCE_WS_MIN) || (cmd_wsize > `SMCE_WS_MAX);
  wire too_big = (bits > `SMCE_CMD_BITS_MAX) || (qsum > `SMCE_Q_BYTES_MAX);
  wire bad_cmd = xfer_cmd && (bad_len || too_big || cmd_count == 32'h0);
  wire [31:0] per_ns = {21'h0, half_q, 1'b0} * `SMCE_CLK_NS;
  wire [31:0] step = nsm_q ? per_ns : 32'h1;
  wire [3:0] rx_chunk = (io_q == `SMCE_IO_SINGLE) ? {3'h0, io_s_q[1]} :
                        (io_s_q & ((4'h1 << bw) - 4'h1));
  wire [31:0] rx_next = lsb_first ? ((rx_q >> bw) | ({28'h0, rx_chunk} << (6'd32 - {3'h0, bw})))
                                  : ((rx_q << bw) | {28'h0, rx_chunk});
  wire [31:0] rx_fin = (lsb_first ? (rx_q >> lsh_q) : (rx_q >> pad_q)) & wmask(ws_q);
  wire [2:0] cbw = lanes(cmd_io);
  wire [5:0] ccyc = (cmd_io == `SMCE_IO_FOUR) ? ((cmd_wsize + 6'd3) >> 2) :
                    (cmd_io == `SMCE_IO_TWO) ? ((cmd_wsize + 6'd1) >> 1) : cmd_wsize;
  wire [5:0] cspan = (cmd_io == `SMCE_IO_FOUR) ? {ccyc[3:0], 2'h0} :
                     (cmd_io == `SMCE_IO_TWO) ? {ccyc[4:0], 1'b0} : ccyc;
  wire [31:0] src = (op_q == `SMCE_OP_STREAM_OUT) ? tx_word :
                    (op_q == `SMCE_OP_REPEAT_OUT) ? arg_q : 32'h0;
  wire [31:0] ld = lsb_first ? src : (src << (6'd32 - ws_q));
  wire in_only = (op_q == `SMCE_OP_STREAM_IN) && (io_q != `SMCE_IO_SINGLE);
  wire [3:0] drv = in_only ? 4'h0 :
                   (io_q == `SMCE_IO_FOUR) ? 4'hf : (io_q == `SMCE_IO_TWO) ? 4'h3 : 4'h1;
  wire gap_on = (word_gap > 16'h1);
  assign cmd_ready = (st_q == `SMCE_ST_IDLE) && !slave_en && rst_n_q;
  assign tx_ready = (st_q == `SMCE_ST_LOAD) && (op_q == `SMCE_OP_STREAM_OUT);
  wire load_go = (st_q == `SMCE_ST_LOAD) && (op_q != `SMCE_OP_STREAM_OUT || tx_valid);
  // Command sequencer, shifter and delay timer
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= `SMCE_ST_IDLE;
      op_q <= 3'h0;
      io_q <= 2'h0;
      ws_q <= 6'h0;
      cyc_q <= 6'h0;
      pad_q <= 6'h0;
      lsh_q <= 6'h0;
      hc_q <= 10'h0;
      half_q <= `SMCE_HALF_DEF;
      rate_q <= `SMCE_RATE_DEF;
      ph_q <= 1'b0;
      nsm_q <= 1'b0;
      out_en_q <= 1'b0;
      rej_q <= 1'b0;
      rxv_q <= 1'b0;
      rspv_q <= 1'b0;
      sclk_q <= 1'b0;
      wcnt_q <= 32'h0;
      wrx_q <= 32'h0;
      arg_q <= 32'h0;
      sr_q <= 32'h0;
      rx_q <= 32'h0;
      rem_q <= 32'h0;
      acc_q <= 32'h0;
      rxw_q <= 32'h0;
      rspval_q <= 32'h0;
      rspw_q <= 32'h0;
      ss_act_q <= 8'h0;
      io_out_q <= 4'h0;
      io_oe_n_q <= 4'hf;
      qbytes_q <= 26'h0;
    end else begin
      rej_q <= 1'b0;
      rxv_q <= 1'b0;
      rspv_q <= 1'b0;
      if (rate_req_valid && rate_req_khz != 17'h0) begin
        {rate_q, half_q} <= rate_pick(rate_req_khz);
      end
      if (queue_begin) qbytes_q <= 26'h0;
      case (st_q)
        `SMCE_ST_IDLE: begin
          sclk_q <= cpol;
          io_out_q <= 4'h0;
          io_oe_n_q <= {3'h7, ~out_en_q};
          hc_q <= 10'h0;
          ph_q <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            op_q <= cmd_op;
            io_q <= cmd_io;
            ws_q <= cmd_wsize;
            arg_q <= cmd_arg;
            wcnt_q <= cmd_count;
            wrx_q <= 32'h0;
            acc_q <= 32'h0;
            rem_q <= cmd_arg;
            cyc_q <= ccyc;
            pad_q <= cspan - cmd_wsize;
            lsh_q <= 6'd32 - cspan;
            nsm_q <= (cmd_op == `SMCE_OP_TIME_GAP);
            if (bad_cmd) begin
              rej_q <= 1'b1;
            end else if (xfer_cmd) begin
              qbytes_q <= qsum[25:0];
              st_q <= `SMCE_ST_LOAD;
            end else begin
              case (cmd_op)
                `SMCE_OP_DRIVE: begin
                  out_en_q <= cmd_arg[0];
                  rspv_q <= 1'b1;
                  rspval_q <= {31'h0, cmd_arg[0]};
                end
                `SMCE_OP_SELECT: begin
                  ss_act_q <= cmd_arg[7:0];
                  rspv_q <= 1'b1;
                  rspval_q <= {24'h0, cmd_arg[7:0]};
                end
                `SMCE_OP_CYC_GAP, `SMCE_OP_TIME_GAP: begin
                  if (cmd_arg == 32'h0 ||
                      (cmd_op == `SMCE_OP_TIME_GAP && cmd_arg > `SMCE_NS_MAX)) begin
                    rspv_q <= 1'b1;
                    rspval_q <= 32'h0;
                  end else begin
                    st_q <= `SMCE_ST_DELAY;
                  end
                end
                default: rej_q <= 1'b1;
              endcase
            end
          end
        end
        `SMCE_ST_DELAY, `SMCE_ST_GAP: begin
          // One serial period per step; time gap rounds up to whole periods
          hc_q <= half_end ? 10'h0 : hc_q + 10'd1;
          if (half_end) ph_q <= ~ph_q;
          if (half_end && ph_q) begin
            if (st_q == `SMCE_ST_GAP) begin
              rem_q <= rem_q - 32'h1;
              if (rem_q == 32'h1) st_q <= `SMCE_ST_LOAD;
            end else begin
              acc_q <= acc_q + step;
              rem_q <= rem_q - step;
              if (rem_q <= step) begin
                st_q <= `SMCE_ST_IDLE;
                rspv_q <= 1'b1;
                rspval_q <= acc_q + step;
              end
            end
          end
        end
        `SMCE_ST_LOAD: begin
          hc_q <= 10'h0;
          ph_q <= 1'b0;
          if (load_go) begin
            sr_q <= ld;
            rx_q <= 32'h0;
            cyc_q <= (io_q == `SMCE_IO_FOUR) ? ((ws_q + 6'd3) >> 2) :
                     (io_q == `SMCE_IO_TWO) ? ((ws_q + 6'd1) >> 1) : ws_q;
            io_out_q <= tx_chunk(ld, bw, lsb_first);
            io_oe_n_q <= ~(drv & {4{out_en_q}});
            sclk_q <= cpol ^ cpha;
            st_q <= `SMCE_ST_SHIFT;
          end
        end
        `SMCE_ST_SHIFT: begin
          hc_q <= half_end ? 10'h0 : hc_q + 10'd1;
          if (half_end && !ph_q) begin
            ph_q <= 1'b1;
            rx_q <= rx_next; // Sample at mid bit
            sclk_q <= cpol ^ ~cpha;
          end else if (half_end) begin
            ph_q <= 1'b0;
            cyc_q <= cyc_q - 6'd1;
            if (cyc_q == 6'd1) begin
              sclk_q <= cpol;
              rxv_q <= 1'b1;
              rxw_q <= rx_fin;
              wrx_q <= wrx_q + 32'h1;
              wcnt_q <= wcnt_q - 32'h1;
              rem_q <= {16'h0, word_gap};
              if (wcnt_q == 32'h1) begin
                st_q <= `SMCE_ST_IDLE;
                rspv_q <= 1'b1;
                rspval_q <= wrx_q + 32'h1;
              end else begin
                st_q <= gap_on ? `SMCE_ST_GAP : `SMCE_ST_LOAD;
              end
            end else begin
              sr_q <= lsb_first ? (sr_q >> bw) : (sr_q << bw);
              io_out_q <= tx_chunk(lsb_first ? (sr_q >> bw) : (sr_q << bw), bw, lsb_first);
              sclk_q <= cpol ^ cpha;
            end
          end
        end
        default: st_q <= `SMCE_ST_IDLE;
      endcase
    end
  end
  // Shared select/GPIO pins with per-line polarity
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ss_out_q <= 8'h0;
      ss_oe_n_q <= 8'hff;
    end else begin
      ss_out_q <= (ss_enable & ~(ss_act_q ^ ss_polarity)) | (~ss_enable & gpio_out);
      ss_oe_n_q <= (ss_enable & {8{~out_en_q}}) | (~ss_enable & gpio_oe_n);
    end
  end
  assign rate_khz = rate_q;
  assign cmd_reject = rej_q;
  assign rx_valid = rxv_q;
  assign rx_word = rxw_q;
  assign resp_valid = rspv_q;
  assign resp_value = rspval_q;
  assign resp_words = wrx_q;
  assign sclk = sclk_q;
  assign sclk_oe_n = ~out_en_q;
  assign ss_pin_out = ss_out_q;
  assign ss_pin_oe_n = ss_oe_n_q;
  assign io_out = io_out_q;
  assign io_oe_n = io_oe_n_q;
endmodule // smce_engine
`default_nettype wire

/* File: verif/smce_engine_props.sv */
// Port checker for the SPI master command engine.
// Assumes binding onto smce_engine; single clk domain.
`default_nettype none
module smce_engine_props (
  input wire clk,
  input wire nrst,
  input wire slave_en,
  input wire [1:0] clock_mode,
  input wire [7:0] ss_polarity,
  input wire [7:0] ss_enable,
  input wire [7:0] gpio_out,
  input wire rate_req_valid,
  input wire [16:0] rate_req_khz,
  input wire [16:0] rate_khz,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [5:0] cmd_wsize,
  input wire [31:0] cmd_arg,
  input wire cmd_reject,
  input wire resp_valid,
  input wire [31:0] resp_value,
  input wire sclk,
  input wire sclk_oe_n,
  input wire [7:0] ss_pin_out
);
  wire take;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Command taken this edge
  assign take = cmd_valid && cmd_ready;
  a_reset_rate: assert property ($rose(nrst) |-> rate_khz == 17'h003e8)
    else $error("rate after reset wrong");
  a_slave_block: assert property (slave_en |-> !cmd_ready)
    else $error("command open while slave on");
  a_rate_keep: assert property (rate_req_valid && rate_req_khz == 17'h0
    |=> $stable(rate_khz))
    else $error("zero rate request changed rate");
  a_rate_min: assert property (rate_req_valid && rate_req_khz != 17'h0
    && rate_req_khz < 17'h1f |=> rate_khz == 17'h0001f)
    else $error("low rate not raised to floor");
  a_size_refuse: assert property (take && cmd_op >= 3'h4
    && (cmd_wsize < 6'h02 || cmd_wsize > 6'h20) |=> cmd_reject && !resp_valid)
    else $error("bad word size not refused");
  a_drive_on: assert property (take && cmd_op == 3'h0 && cmd_arg[0]
    |=> resp_valid ##[0:1] !sclk_oe_n)
    else $error("drive command did not enable clock");
  a_gap_none: assert property (take && cmd_op == 3'h3 && cmd_arg == 32'h0
    |=> resp_valid && resp_value == 32'h0)
    else $error("zero time gap not answered with 0");
  // Pins show the mask two edges after the take, whatever follows it
  a_select_pins: assert property (take && cmd_op == 3'h1
    |=> ##1 (((ss_pin_out ~^ ss_polarity) ^ $past(cmd_arg[7:0], 2)) & ss_enable) == 8'h00)
    else $error("select pins wrong");
  a_gpio_pass: assert property ($past(nrst, 3) && $stable(gpio_out) && $stable(ss_enable)
    |-> ((ss_pin_out ^ gpio_out) & ~ss_enable) == 8'h00)
    else $error("gpio pin not passed through");
  a_idle_level: assert property (cmd_ready && $past(cmd_ready) && $stable(clock_mode)
    |-> sclk == clock_mode[1])
    else $error("idle clock level wrong");
endmodule // smce_engine_props
bind smce_engine smce_engine_props chk_u (.*);
`default_nettype wire

/* File: verif/smce_slave_model.sv */
// Behavioural SPI slave on select line zero.
// Assumes the bench hands it the decoded select level and mode.
`default_nettype none
module smce_slave_model #(parameter logic [31:0] RESP = 32'h96c35a0f) (
  input wire logic sclk,
  input wire logic sel,
  input wire logic [1:0] mode,
  input wire logic mosi,
  output logic miso,
  output logic [31:0] rx_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] tx_q = 32'h0;
  logic rise_s;
  logic fresh_q = 1'b0;
  // Sampling edge follows the shared clock mode
  assign rise_s = mode[1] == mode[0];
  // A released line shows the inverse of its last bit
  assign miso = sel ? tx_q[31] : ~tx_q[31];
  // Reload the reply when selected
  always @(posedge sel) begin
    tx_q = RESP;
    rx_bits = 32'h0;
    fresh_q = 1'b1;
  end
  // Take data on the sampling edge, shift reply on the other; in the late
  // phase modes the first bit is held over the first leading edge
  always @(sclk) begin
    if (sel && sclk == rise_s) rx_bits = {rx_bits[30:0], mosi};
    if (sel && sclk != rise_s) begin
      if (!(mode[0] && fresh_q)) tx_q = tx_q << 1;
      fresh_q = 1'b0;
    end
  end
endmodule // smce_slave_model
`default_nettype wire

/* File: verif/smce_engine_tb.sv */
// Self-checking bench for the SPI master command engine.
// Assumes rtl/ on the include path, the checker and slave model.
`include "smce_defines.vh"
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin failures++; \
  $display("FAIL %s exp %h got %h", nm, ex, gt); end end
module smce_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, slave_en = 0, lsb_first = 0, rate_req_valid = 0;
  logic queue_begin = 0, cmd_valid = 0, tx_valid = 0, rej;
  logic [1:0] clock_mode = 2'h0, cmd_io = 2'h0;
  logic [7:0] ss_polarity = 8'h05, ss_enable = 8'h0f, gpio_out = 8'h5a;
  logic [7:0] gpio_oe_n = 8'hff, nib;
  logic [3:0] oen;
  logic [15:0] word_gap = 16'h0;
  logic [16:0] rate_req_khz = 17'h0;
  logic [2:0] cmd_op = 3'h0;
  logic [5:0] cmd_wsize = 6'h0;
  logic [31:0] cmd_count = 32'h0, cmd_arg = 32'h0, tx_word = 32'h0, got;
  wire [16:0] rate_khz;
  wire cmd_ready, cmd_reject, tx_ready, rx_valid, resp_valid, sclk, sclk_oe_n, miso;
  wire [31:0] rx_word, resp_value, resp_words, slv_rx;
  wire [7:0] ss_pin_out, ss_pin_oe_n;
  wire [3:0] io_out, io_oe_n, io_in;
  int failures = 0, n_tests = 0, waited, nrx;
  // Released data lines read back inverted; line 1 is the slave reply
  assign io_in = {~io_out[3:2], miso, ~io_out[0]};
  smce_engine dut_u (.*);
  smce_slave_model slv_u (.sclk(sclk), .sel(ss_pin_out[0] == ss_polarity[0]),
    .mode(clock_mode), .mosi(io_out[0]), .miso(miso), .rx_bits(slv_rx));
  // Clock and data-line capture at each rising serial edge
  initial forever #12.5 clk = ~clk;
  always @(posedge sclk) begin
    nib = {nib[3:0], io_out};
    oen = io_oe_n;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One command: hold until taken, then wait for its answer
  task automatic cmd(input logic [2:0] op, input logic [5:0] ws, input logic [31:0] cnt,
    input logic [31:0] arg);
    int i;
    @(posedge clk) #1;
    cmd_op = op;
    cmd_wsize = ws;
    cmd_count = cnt;
    cmd_arg = arg;
    cmd_valid = 1'b1;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i >= 200) begin
      failures++;
      end_of_test;
    end
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    nrx = 0;
    for (i = 0; i < 30000 && resp_valid !== 1'b1 && cmd_reject !== 1'b1; i++) begin
      @(posedge clk) #1;
      if (rx_valid === 1'b1) nrx++;
    end
    if (i >= 30000) begin
      failures++;
      end_of_test;
    end
    waited = i;
    got = resp_value;
    rej = cmd_reject;
  endtask
  task automatic t_rate;
    logic [16:0] rq[4] = '{17'h00000, 17'h00bb8, 17'h00014, 17'h01388};
    logic [16:0] ex[4] = '{17'h003e8, 17'h007d0, 17'h0001f, 17'h01388};
    for (int i = 0; i < 4; i++) begin
      rate_req_khz = rq[i];
      rate_req_valid = 1'b1;
      @(posedge clk) #1;
      rate_req_valid = 1'b0;
      @(posedge clk) #1;
      `CHK("rate", ex[i], rate_khz)
    end
    $display("rate table done");
  endtask
  task automatic t_pins;
    cmd(`SMCE_OP_DRIVE, 6'h0, 32'h0, 32'h1);
    `CHK("clock drive", 1'b0, sclk_oe_n)
    cmd(`SMCE_OP_SELECT, 6'h0, 32'h0, 32'h1);
    @(posedge clk) #1;
    `CHK("pins", 8'h5b, ss_pin_out)
    `CHK("pin enables", 8'hf0, ss_pin_oe_n)
    `CHK("data enable", 4'he, io_oe_n)
    $display("pins done");
  endtask
  task automatic t_modes;
    word_gap = 16'h3;
    for (int m = 0; m < 5; m++) begin
      clock_mode = m[1:0];
      lsb_first = (m == 4);
      cmd(`SMCE_OP_SELECT, 6'h0, 32'h0, 32'h0);
      cmd(`SMCE_OP_SELECT, 6'h0, 32'h0, 32'h1);
      cmd(`SMCE_OP_REPEAT_OUT, 6'h08, 32'h2, 32'h4b);
      `CHK("words in", 32'h2, got)
      `CHK("rx beats", 32'h2, nrx)
      `CHK("resp words", 32'h2, resp_words)
      `CHK("slave rx", lsb_first ? 16'hd2d2 : 16'h4b4b, slv_rx[15:0])
      `CHK("reply", 32'h000000c3, rx_word)
    end
    lsb_first = 1'b0;
    clock_mode = 2'h0;
    cmd_io = `SMCE_IO_FOUR;
    cmd(`SMCE_OP_REPEAT_OUT, 6'h08, 32'h1, 32'h4b);
    `CHK("four line", 8'h4b, nib)
    `CHK("four line oe", 4'h0, oen)
    cmd(`SMCE_OP_STREAM_IN, 6'h08, 32'h1, 32'h0);
    `CHK("four line in", 4'hf, oen)
    `CHK("in words", 32'h1, got)
    cmd_io = `SMCE_IO_SINGLE;
    tx_word = 32'h5a;
    tx_valid = 1'b1;
    cmd(`SMCE_OP_STREAM_OUT, 6'h08, 32'h1, 32'h0);
    tx_valid = 1'b0;
    `CHK("stream out", 8'h5a, slv_rx[7:0])
    `CHK("tx idle", 1'b0, tx_ready)
    $display("modes done");
  endtask
  task automatic t_gaps;
    logic [31:0] rq[4] = '{32'h0, 32'h77359401, 32'h3e8, 32'h3e9};
    logic [31:0] ex[4] = '{32'h0, 32'h0, 32'h3e8, 32'h4b0};
    cmd(`SMCE_OP_CYC_GAP, 6'h0, 32'h0, 32'h3);
    `CHK("cycle gap", 32'h3, got)
    `CHK("gap length", 1'b1, waited >= 23)
    for (int i = 0; i < 4; i++) begin
      cmd(`SMCE_OP_TIME_GAP, 6'h0, 32'h0, rq[i]);
      `CHK("time gap", ex[i], got)
    end
    $display("gaps done");
  endtask
  task automatic t_refuse;
    cmd(`SMCE_OP_REPEAT_OUT, 6'h01, 32'h1, 32'h1);
    `CHK("size 1", 1'b1, rej)
    cmd(`SMCE_OP_REPEAT_OUT, 6'h21, 32'h1, 32'h1);
    `CHK("size 33", 1'b1, rej)
    cmd(`SMCE_OP_STREAM_OUT, 6'h08, 32'h0, 32'h0);
    `CHK("count 0", 1'b1, rej)
    slave_en = 1'b1;
    repeat (2) @(posedge clk) #1;
    `CHK("slave lock", 1'b0, cmd_ready)
    slave_en = 1'b0;
    $display("refusals done");
  endtask
  initial begin
    repeat (3) @(posedge clk) #1;
    `CHK("reset clock", 1'b1, sclk_oe_n)
    nrst = 1'b1;
    repeat (3) @(posedge clk) #1;
    `CHK("rate", 17'h003e8, rate_khz)
    t_rate;
    t_pins;
    t_modes;
    t_gaps;
    t_refuse;
    end_of_test;
  end
endmodule // smce_engine_tb
`default_nettype wire
